// ==== rtl/spi_mem_map.vh ====
// Purpose: constants of the serial memory command front end
// Assumes: 250 MHz system clock, serial clock up to 40 MHz
// Notes: opcodes, status layout, address width
`ifndef SPI_MEM_MAP_VH
`define SPI_MEM_MAP_VH

// ****************************************
// command opcodes
// ****************************************
`define OP_LATCH_SET 8'h06
`define OP_LATCH_RESET 8'h04
`define OP_STATUS_READ 8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_READ 8'h03
`define OP_FAST_READ 8'h0b
`define OP_WRITE 8'h02
`define OP_SLEEP 8'hb9
`define OP_ID_READ 8'h9f

// ****************************************
// memory and status layout
// ****************************************
`define MEM_DEPTH 16384
`define ADDR_W 14
`define ADDR_LAST 14'h3fff
`define ST_PROTECT_PIN_EN 7
`define ST_BLOCK_HIGH 3
`define ST_BLOCK_LOW 2
`define ST_WEL 1
`define ST_RESET 8'h00
`define FIFO_DEPTH 8

`endif

// ==== rtl/spi_mem_front.v ====
// Purpose: serial memory slave front end with byte memory and status
// Assumes: serial pins are asynchronous and sampled by mclk_i
// Notes: serial clock must stay well below a quarter of mclk_i
`timescale 1ns/1ps
`include "spi_mem_map.vh"

// ****************************************
// receive byte fifo
// ****************************************
module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // clock and reset
    input wire mclk_i,
    input wire srst_i,
    // fill side
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    // drain side
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_reg;
    reg [AW-1:0] rd_reg;
    reg [AW:0] cnt_reg;
    wire push;
    wire pop;

    // honest full and empty from the count
    assign in_ready_o = (cnt_reg != DEPTH[AW:0]);
    assign out_valid_o = (cnt_reg != {(AW+1){1'b0}});
    assign out_data_o = mem[rd_reg];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // pointer and count update
    always @(posedge mclk_i) begin
        if (srst_i) begin
            wr_reg <= {AW{1'b0}};
            rd_reg <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= rd_reg + 1'b1;
            end
            if (push & ~pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (pop & ~push) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end

    // storage write
    always @(posedge mclk_i) begin
        if (push) begin
            mem[wr_reg] <= in_data_i;
        end
    end
endmodule

// Operation
// - 16384 bytes, 14-bit unique address
// - two address bytes, top two bits ignored
// - slave, modes 0 and 3 only
// - sample rising edges, shift out falling
// - clock level at select picks mode
// - mode 3 skips initial falling toggle
// - first byte after select is opcode
// - deselected: ignore input, output tristated
// - all bytes shift msb first
// - invalid opcode: ignore until next select
// - decode latch set, reset, status read
// - decode status write, read, fast read
// - decode write, sleep, identification read
// - writes complete at bus speed
// - one 8-bit status register
// - never starts a transfer itself
// - hold low suspends and tristates output
// - latch set by set, cleared at end
// - status bit layout, unused bits zero
// - sequential address wraps 3fff to 0000
module spi_mem_front (
    // clock and reset
    input wire mclk_i,
    input wire srst_i,
    // serial pins
    input wire sck_i,
    input wire cs_n_i,
    input wire si_i,
    input wire hold_n_i,
    input wire wp_n_i,
    output reg so_o,
    output wire so_oe_o,
    // status and observation
    output wire [7:0] status_o,
    output wire mode3_o,
    output wire sleep_o,
    output wire busy_o
);
    // device identification, value arbitrary
    parameter [7:0] DEVICE_ID_BYTE = 8'h5a;

    localparam ST_IDLE = 3'd0;
    localparam ST_OPC = 3'd1;
    localparam ST_ADDR = 3'd2;
    localparam ST_DATA = 3'd3;
    localparam ST_IGNORE = 3'd4;

    // ****************************************
    // pin synchronisers
    // ****************************************
    reg [1:0] sck_s, cs_s, si_s, hold_s, wp_s;
    reg sck_d_reg, cs_d_reg;
    reg [7:0] mem [0:`MEM_DEPTH-1];

    // two flops on every pin
    always @(posedge mclk_i) begin
        sck_s <= {sck_s[0], sck_i};
        cs_s <= {cs_s[0], cs_n_i};
        si_s <= {si_s[0], si_i};
        hold_s <= {hold_s[0], hold_n_i};
        wp_s <= {wp_s[0], wp_n_i};
    end

    wire sck = sck_s[1];
    wire cs_n = cs_s[1];
    wire hold_ok = hold_s[1];
    wire sck_rise = sck & ~sck_d_reg & hold_ok;
    wire sck_fall = ~sck & sck_d_reg & hold_ok;
    wire cs_fall = ~cs_n & cs_d_reg & hold_ok;
    wire cs_rise = cs_n & ~cs_d_reg & hold_ok;

    // ****************************************
    // protocol state
    // ****************************************
    reg [2:0] state_reg, bit_reg;
    reg [7:0] shift_reg, opcode_reg, out_reg;
    reg [`ADDR_W-1:0] addr_reg;
    reg addr_byte_reg, mode3_reg, armed_reg, driving_reg;
    reg wel_reg, wel_clr_reg, protect_pin_enable_reg, sleep_reg, fast_dummy_reg;
    reg [1:0] bp_reg;

    // opcode membership in the nine command set
    function is_valid_op;
        input [7:0] op;
        begin
            case (op)
                `OP_LATCH_SET, `OP_LATCH_RESET,
                `OP_STATUS_READ: is_valid_op = 1'b1;
                `OP_STATUS_WRITE, `OP_READ,
                `OP_FAST_READ: is_valid_op = 1'b1;
                `OP_WRITE, `OP_SLEEP,
                `OP_ID_READ: is_valid_op = 1'b1;
                default: is_valid_op = 1'b0;
            endcase
        end
    endfunction

    // block protection test for a write address
    function is_protected;
        input [1:0] bp;
        input [`ADDR_W-1:0] a;
        begin
            case (bp)
                2'b01: is_protected = (a[13:12] == 2'b11);
                2'b10: is_protected = a[13];
                2'b11: is_protected = 1'b1;
                default: is_protected = 1'b0;
            endcase
        end
    endfunction

    wire [7:0] status_val = {protect_pin_enable_reg, 3'b000, bp_reg, wel_reg,
                             1'b0};
    wire [7:0] rx_byte = {shift_reg[6:0], si_s[1]};
    wire byte_done = sck_rise & (bit_reg == 3'd7);
    wire st_wr_ok = wel_reg & ~(protect_pin_enable_reg & ~wp_s[1]);

    // ****************************************
    // received write data bytes pass through fifo
    // ****************************************
    wire rx_push = byte_done & armed_reg & (state_reg == ST_DATA) &
                   (opcode_reg == `OP_WRITE);
    wire fifo_valid;
    wire [21:0] fifo_data;
    // unlatched or block protected writes never reach memory
    wire wr_blocked = ~wel_reg | is_protected(bp_reg, fifo_data[21:8]);

    // address travels with its byte, drain always ready
    byte_fifo #(
        .WIDTH(22),
        .DEPTH(`FIFO_DEPTH),
        .AW(3)
    ) u_fifo (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .in_valid_i(rx_push),
        .in_ready_o(),
        .in_data_i({addr_reg, rx_byte}),
        .out_valid_o(fifo_valid),
        .out_ready_i(1'b1),
        .out_data_o(fifo_data)
    );

    // memory write as each word drains
    always @(posedge mclk_i) begin
        if (fifo_valid && !wr_blocked) begin
            mem[fifo_data[21:8]] <= fifo_data[7:0];
        end
    end

    // ****************************************
    // main serial state machine
    // ****************************************
    always @(posedge mclk_i) begin
        if (srst_i) begin
            state_reg <= ST_IDLE;
            bit_reg <= 3'h0;
            shift_reg <= 8'h00;
            opcode_reg <= 8'h00;
            out_reg <= 8'h00;
            addr_reg <= {`ADDR_W{1'b0}};
            addr_byte_reg <= 1'b0;
            mode3_reg <= 1'b0;
            armed_reg <= 1'b0;
            driving_reg <= 1'b0;
            wel_reg <= 1'b0;
            wel_clr_reg <= 1'b0;
            protect_pin_enable_reg <= 1'b0;
            bp_reg <= 2'b00;
            sleep_reg <= 1'b0;
            fast_dummy_reg <= 1'b0;
            so_o <= 1'b0;
            sck_d_reg <= 1'b0;
            cs_d_reg <= 1'b1;
        end else begin
            if (hold_ok) begin
                sck_d_reg <= sck;
                cs_d_reg <= cs_n;
            end
            if (cs_rise) begin
                // partial opcode simply dropped
                state_reg <= ST_IDLE;
                driving_reg <= 1'b0;
                if (wel_clr_reg) begin
                    wel_reg <= 1'b0;
                end
                wel_clr_reg <= 1'b0;
            end else if (cs_fall) begin
                mode3_reg <= sck;
                armed_reg <= ~sck;
                state_reg <= ST_OPC;
                bit_reg <= 3'h0;
                sleep_reg <= 1'b0;
                driving_reg <= 1'b0;
            end else if (state_reg != ST_IDLE && !cs_n) begin
                if (sck_fall) begin
                    armed_reg <= 1'b1;
                    if (driving_reg) begin
                        so_o <= out_reg[7];
                        out_reg <= {out_reg[6:0], 1'b0};
                    end
                end
                if (sck_rise && armed_reg && state_reg != ST_IGNORE) begin
                    shift_reg <= rx_byte;
                    bit_reg <= bit_reg + 3'h1;
                end
                if (byte_done && armed_reg) begin
                    case (state_reg)
                        ST_OPC: begin
                            opcode_reg <= rx_byte;
                            addr_byte_reg <= 1'b0;
                            fast_dummy_reg <= (rx_byte == `OP_FAST_READ);
                            if (!is_valid_op(rx_byte)) begin
                                state_reg <= ST_IGNORE;
                            end else begin
                                case (rx_byte)
                                    `OP_LATCH_SET: wel_reg <= 1'b1;
                                    `OP_LATCH_RESET, `OP_WRITE,
                                    `OP_STATUS_WRITE: begin
                                        wel_clr_reg <= 1'b1;
                                    end
                                    `OP_SLEEP: sleep_reg <= 1'b1;
                                    default: ;
                                endcase
                                case (rx_byte)
                                    `OP_READ, `OP_FAST_READ,
                                    `OP_WRITE: state_reg <= ST_ADDR;
                                    `OP_STATUS_READ: begin
                                        state_reg <= ST_DATA;
                                        out_reg <= status_val;
                                        driving_reg <= 1'b1;
                                    end
                                    `OP_ID_READ: begin
                                        state_reg <= ST_DATA;
                                        out_reg <= DEVICE_ID_BYTE;
                                        driving_reg <= 1'b1;
                                    end
                                    `OP_STATUS_WRITE: state_reg <= ST_DATA;
                                    default: state_reg <= ST_IGNORE;
                                endcase
                            end
                        end
                        ST_ADDR: begin
                            addr_byte_reg <= 1'b1;
                            if (!addr_byte_reg) begin
                                addr_reg[13:8] <= rx_byte[5:0];
                            end else begin
                                addr_reg[7:0] <= rx_byte;
                                state_reg <= ST_DATA;
                                if (opcode_reg == `OP_READ) begin
                                    out_reg <= mem[{addr_reg[13:8],
                                                    rx_byte}];
                                    driving_reg <= 1'b1;
                                end
                            end
                        end
                        ST_DATA: begin
                            if (fast_dummy_reg) begin
                                // dummy byte done, start output
                                fast_dummy_reg <= 1'b0;
                                out_reg <= mem[addr_reg];
                                driving_reg <= 1'b1;
                            end else if (opcode_reg == `OP_STATUS_WRITE) begin
                                if (st_wr_ok) begin
                                    protect_pin_enable_reg <= rx_byte[`ST_PROTECT_PIN_EN];
                                    bp_reg <= rx_byte[3:2];
                                end
                                state_reg <= ST_IGNORE;
                            end else if (opcode_reg == `OP_WRITE) begin
                                addr_reg <= addr_reg + 14'h1;
                            end else if (opcode_reg == `OP_STATUS_READ) begin
                                out_reg <= status_val;
                            end else if (opcode_reg == `OP_ID_READ) begin
                                out_reg <= DEVICE_ID_BYTE;
                            end else begin
                                out_reg <= mem[addr_reg + 14'h1];
                                addr_reg <= addr_reg + 14'h1;
                            end
                        end
                        default: ;
                    endcase
                end
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // tristate while deselected, on hold or ignoring
    assign so_oe_o = driving_reg & ~cs_n & hold_ok &
                     (state_reg == ST_DATA);
    assign status_o = status_val;
    assign mode3_o = mode3_reg;
    assign sleep_o = sleep_reg;
    assign busy_o = (state_reg != ST_IDLE);
endmodule

// ==== verif/spi_mem_front_sva.sv ====
// Purpose: protocol checks on the memory front end ports
// Assumes: pins sampled by mclk_i, sck period far above mclk_i
// Notes: attached from the testbench top file
`timescale 1ns/1ps

// ****************************************
// port checker
// ****************************************
module spi_mem_front_sva (
    // clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    // serial pins
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    input wire logic hold_n_i,
    input wire logic wp_n_i,
    input wire logic so_o,
    input wire logic so_oe_o,
    // status and observation
    input wire logic [7:0] status_o,
    input wire logic mode3_o,
    input wire logic sleep_o,
    input wire logic busy_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    // deselected device is silent and idle
    a_deselect_quiet: assert property (
        cs_n_i [*6] |-> !so_oe_o && !busy_o)
        else $error("output driven while deselected");
    a_hold_quiet: assert property (
        !hold_n_i [*6] |-> !so_oe_o)
        else $error("output driven during hold");
    a_status_zeros: assert property (
        status_o[6:4] == 3'h0 && !status_o[0])
        else $error("fixed status bits not zero");
    // output moves only just after a falling serial edge
    a_so_falling_edge: assert property (
        so_oe_o && $past(so_oe_o) && $changed(so_o) |->
        !$past(sck_i) && !$past(sck_i, 2) && $past(sck_i, 10))
        else $error("output changed away from falling edge");
    a_mode3_pick: assert property (
        $fell(cs_n_i) && sck_i |-> ##[2:6] mode3_o)
        else $error("mode 3 not taken");
    a_mode0_pick: assert property (
        $fell(cs_n_i) && !sck_i |-> ##[2:6] !mode3_o)
        else $error("mode 0 not taken");
    a_sleep_wakes: assert property (
        $fell(cs_n_i) |-> ##[1:8] !sleep_o)
        else $error("sleep kept after select");
    a_status_idle: assert property (
        cs_n_i [*8] |-> $stable(status_o))
        else $error("status changed while idle");
    a_no_self_start: assert property (
        !busy_o [*2] |-> !so_oe_o)
        else $error("output driven outside a frame");

    // main scenarios reached
    cover property ($rose(so_oe_o));
    cover property ($rose(mode3_o));
    cover property ($rose(sleep_o));
endmodule

// ==== verif/spi_master_model.sv ====
// Purpose: serial bus master model facing the memory front end
// Assumes: link clock half period 62.5 ns, free of mclk_i
// Notes: released data line is inverted so no stale level remains
`timescale 1ns/1ps

// ****************************************
// serial master model
// ****************************************
module spi_master_model (
    // serial pins towards the slave
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o,
    input wire logic so_i
);
    localparam real HALF = 62.5;

    // idle: deselected, clock low
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end

    // park clock at mode level, then select
    task start(input bit m3);
        sck_o = m3;
        #HALF cs_n_o = 1'b0;
        #HALF;
    endtask

    // n bits msb first, slave sampled at each rising edge
    task shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            sck_o = 1'b0;
            si_o = tx[i];
            #HALF;
            rx = {rx[6:0], so_i};
            sck_o = 1'b1;
            #HALF;
        end
    endtask

    // clock low between bytes
    task lower;
        sck_o = 1'b0;
        #HALF;
    endtask

    // back to idle level, deselect, release data
    task stop(input bit m3);
        sck_o = m3;
        #HALF cs_n_o = 1'b1;
        si_o = ~si_o;
        #(2 * HALF);
    endtask

    // one command per select, bytes left aligned in tx
    task frame(input bit m3, input int n, input logic [63:0] tx,
            output logic [63:0] rx);
        logic [7:0] b;
        rx = 64'h0;
        start(m3);
        for (int k = 0; k < n; k++) begin
            shift(tx[63 - 8 * k -: 8], 8, b);
            rx[63 - 8 * k -: 8] = b;
        end
        stop(m3);
    endtask
endmodule

// ==== verif/testbench.sv ====
// Purpose: self-checking bench of the memory front end
// Assumes: master model drives clock, select and data in; bench drives hold and protect
// Notes: expectations come from opcodes and status layout
`timescale 1ns/1ps
`include "spi_mem_map.vh"
`define CHECK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    n_fail++; $display("ERROR %s expected %h seen %h", nm, e, g); end end

// ****************************************
// bench top
// ****************************************
module testbench;
    localparam [7:0] ID_BYTE = 8'h69; // arbitrary identification value
    logic mclk_i = 0, srst_i = 1, hold_n_i = 1, wp_n_i = 1, so_float = 0;
    wire sck, cs_n, si, so_o, so_oe_o, mode3_o, sleep_o, busy_o, so_line;
    wire [7:0] status_o;
    int n_fail = 0, n_compared = 0;
    logic [63:0] rx;
    logic [7:0] b;

    // clock and an undriven line that wanders
    initial forever #2 mclk_i = ~mclk_i;
    always @(posedge mclk_i) so_float <= ~so_float;
    assign so_line = so_oe_o ? so_o : so_float;

    spi_mem_front #(.DEVICE_ID_BYTE(ID_BYTE)) i_dut (.mclk_i(mclk_i),
        .srst_i(srst_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
        .hold_n_i(hold_n_i), .wp_n_i(wp_n_i), .so_o(so_o),
        .so_oe_o(so_oe_o), .status_o(status_o), .mode3_o(mode3_o),
        .sleep_o(sleep_o), .busy_o(busy_o));
    spi_master_model i_mst (.sck_o(sck), .cs_n_o(cs_n), .si_o(si),
        .so_i(so_line));

    task test_done;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // link edges start off the clock grid, never on a sampling edge
    task run(input bit m3, input int n, input logic [63:0] tx);
        @(posedge mclk_i);
        #1.25;
        i_mst.frame(m3, n, tx, rx);
    endtask

    task pins(input logic h, input logic w);
        @(posedge mclk_i);
        #1.25 hold_n_i = h;
        wp_n_i = w;
    endtask

    // hang guard
    initial begin
        #300000 n_fail++;
        $display("ERROR watchdog expected end seen hang");
        test_done;
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge mclk_i);
        #1.25 srst_i = 0;
        repeat (8) @(posedge mclk_i);
        `CHECK("status", 8'h00, status_o)
        `CHECK("so_oe", 1'b0, so_oe_o)
        $display("test reset done");
        run(0, 1, {`OP_LATCH_SET, 56'h0});
        `CHECK("status", 8'h02, status_o)
        run(1, 2, {`OP_STATUS_READ, 56'h0});
        `CHECK("mode3", 1'b1, mode3_o)
        `CHECK("status byte", 8'h02, rx[55:48])
        run(0, 1, {`OP_LATCH_RESET, 56'h0});
        `CHECK("mode3", 1'b0, mode3_o)
        `CHECK("status", 8'h00, status_o)
        $display("test latch done");
        run(0, 2, {`OP_STATUS_WRITE, 8'hff, 48'h0});
        `CHECK("status", 8'h00, status_o)
        run(0, 1, {`OP_LATCH_SET, 56'h0});
        run(0, 2, {`OP_STATUS_WRITE, 8'hff, 48'h0});
        `CHECK("status", 8'h8c, status_o)
        pins(1, 0);
        run(0, 1, {`OP_LATCH_SET, 56'h0});
        run(0, 2, {`OP_STATUS_WRITE, 8'h00, 48'h0});
        `CHECK("status", 8'h8c, status_o)
        pins(1, 1);
        run(0, 1, {`OP_LATCH_SET, 56'h0});
        run(0, 2, {`OP_STATUS_WRITE, 8'h00, 48'h0});
        `CHECK("status", 8'h00, status_o)
        $display("test status done");
        run(1, 1, {`OP_LATCH_SET, 56'h0});
        run(1, 5, {`OP_WRITE, 16'hffff, 8'ha5, 8'h3c, 24'h0});
        `CHECK("status", 8'h00, status_o)
        run(0, 5, {`OP_READ, 16'h3fff, 40'h0});
        `CHECK("top byte", 8'ha5, rx[39:32])
        `CHECK("wrapped byte", 8'h3c, rx[31:24])
        run(1, 5, {`OP_FAST_READ, 16'hc000, 40'h0});
        `CHECK("fast byte", 8'h3c, rx[31:24])
        run(0, 1, {`OP_LATCH_SET, 56'h0});
        run(0, 2, {`OP_STATUS_WRITE, 8'h04, 48'h0});
        run(0, 1, {`OP_LATCH_SET, 56'h0});
        run(0, 4, {`OP_WRITE, 16'h3fff, 8'h11, 32'h0});
        run(0, 4, {`OP_READ, 16'h3fff, 40'h0});
        `CHECK("guarded byte", 8'ha5, rx[39:32])
        run(0, 1, {`OP_LATCH_SET, 56'h0});
        run(0, 2, {`OP_STATUS_WRITE, 8'h00, 48'h0});
        run(0, 4, {`OP_WRITE, 16'h3fff, 8'h11, 32'h0});
        run(0, 4, {`OP_READ, 16'h3fff, 40'h0});
        `CHECK("unlatched byte", 8'ha5, rx[39:32])
        $display("test memory done");
        run(0, 2, {`OP_ID_READ, 56'h0});
        `CHECK("id byte", ID_BYTE, rx[55:48])
        run(0, 1, {`OP_SLEEP, 56'h0});
        `CHECK("sleep", 1'b1, sleep_o)
        run(0, 3, {8'hff, `OP_LATCH_SET, `OP_STATUS_READ, 40'h0});
        `CHECK("sleep", 1'b0, sleep_o)
        `CHECK("status", 8'h00, status_o)
        i_mst.start(0);
        i_mst.shift(`OP_LATCH_SET, 7, b);
        i_mst.stop(0);
        `CHECK("status", 8'h00, status_o)
        $display("test opcodes done");
        i_mst.start(0);
        i_mst.shift(`OP_READ, 8, b);
        i_mst.shift(8'h3f, 8, b);
        i_mst.shift(8'hff, 8, b);
        i_mst.lower();
        pins(0, 1);
        repeat (50) @(posedge mclk_i);
        `CHECK("so_oe", 1'b0, so_oe_o)
        `CHECK("busy", 1'b1, busy_o)
        pins(1, 1);
        repeat (25) @(posedge mclk_i);
        #1.25;
        i_mst.shift(8'h00, 8, b);
        i_mst.stop(0);
        `CHECK("held byte", 8'ha5, b)
        $display("test hold done");
        test_done;
    end
endmodule

bind spi_mem_front spi_mem_front_sva i_sva (.mclk_i(mclk_i),
    .srst_i(srst_i), .sck_i(sck_i), .cs_n_i(cs_n_i), .si_i(si_i),
    .hold_n_i(hold_n_i), .wp_n_i(wp_n_i), .so_o(so_o),
    .so_oe_o(so_oe_o), .status_o(status_o), .mode3_o(mode3_o),
    .sleep_o(sleep_o), .busy_o(busy_o));
